// [qrst_pkg.sv]
// package: constants and types of the quasi-resonant switch timing core
package qrst_pkg;
	// --------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int CLK_NS = 40;
	// update period of the valley target counter
	localparam int UPDATE_PERIOD_MS = 48;
	localparam int UPDATE_CYCLES = UPDATE_PERIOD_MS * (CLK_HZ / 1000);
	// line selection blanking time
	localparam int LINE_BLANK_US = 500;
	localparam int LINE_BLANK_CYCLES = LINE_BLANK_US * (CLK_HZ / 1000000);
	// ringing suppression times
	localparam int SHORT_SUPP_NS = 2500;
	localparam int LONG_SUPP_NS = 25000;
	localparam int SHORT_SUPP_CYCLES = (SHORT_SUPP_NS + CLK_NS - 1) / CLK_NS;
	localparam int LONG_SUPP_CYCLES = (LONG_SUPP_NS + CLK_NS - 1) / CLK_NS;
	// max off time, keeps switching above 20 kHz
	localparam int MAX_OFF_NS = 42500;
	localparam int MAX_OFF_CYCLES = MAX_OFF_NS / CLK_NS;
	// leading edge blanking, minimum on time
	localparam int LEB_NS = 250;
	localparam int LEB_CYCLES = (LEB_NS + CLK_NS - 1) / CLK_NS;
	// max on time
	localparam int MAX_ON_NS = 30000;
	localparam int MAX_ON_CYCLES = MAX_ON_NS / CLK_NS;
	// short-to-ground sampling instant after turn-on
	localparam int SHORT_SAMPLE_NS = 2000;
	localparam int SHORT_SAMPLE_CYCLES = (SHORT_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
	// consecutive short pulses before protection
	localparam logic [1:0] SHORT_PULSES = 2'h3;
	// --------------------------------------------------------------
	// valley target limits
	// --------------------------------------------------------------
	localparam logic [3:0] LOW_MIN = 4'h1;
	localparam logic [3:0] LOW_MAX = 4'h8;
	localparam logic [3:0] HIGH_MIN = 4'h3;
	localparam logic [3:0] HIGH_MAX = 4'ha;
	localparam logic [3:0] TARGET_RESET = 4'h1;
	localparam logic [3:0] VALLEY_RESET = 4'h0;
	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		QRST_OFF_SUPP = 2'b00,
		QRST_OFF_WAIT = 2'b01,
		QRST_ON = 2'b11
	} qrst_state_type;
	// comparator flags from the analog front end
	typedef struct packed {
		logic line_above_ref;   // line_sense_voltage above line_select_reference
		logic fb_over_up;       // feedback_level above count_up_threshold
		logic fb_over_down;     // feedback_level above count_down_threshold
		logic fb_over_reload;   // feedback_level above counter_reload_threshold
		logic valley_below_ct;  // valley_sense_input below valley_crossing_threshold
		logic valley_below_rs;  // valley_sense_input below suppression_select_threshold
		logic current_over_fb;  // scaled_current_level above feedback_level
		logic sense_below_short; // current sense below sense_short_threshold
	} qrst_flags_type;
endpackage

// [qrst_sync.sv]
// module: three-stage synchroniser with agreement filter for flag inputs
`timescale 1ns/1ps
module qrst_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk, // core clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic [WIDTH-1:0] din, // asynchronous inputs
	output logic [WIDTH-1:0] dout // filtered synchronous outputs
);
	// --------------------------------------------------------------
	// per-bit chain, change taken when stages two and three agree
	// --------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic q_reg;
			// each bit owns its chain, one process per register set
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					q_reg <= 1'b0;
				end else begin
					s1_reg <= din[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						q_reg <= s3_reg;
					end
				end
			end
			assign dout[i] = q_reg; // filtered level
		end
	endgenerate
endmodule // qrst_sync

// [qrst_core.sv]
// module: switching timing core of a quasi-resonant flyback controller
`timescale 1ns/1ps
// Operation
// - minimum valley target is 1 at low line, 3 at high line
// - line selection changes only after the comparison holds for the blanking time
// - feedback thresholds are evaluated every 48 ms and the target updated
// - feedback always below up threshold: increment, saturating at 8 or 10
// - above up but never above down threshold: target unchanged
// - above down but never reload threshold: decrement, saturating at 1 or 3
// - above reload threshold: load target with the line minimum
// - target stays within 1..8 or 3..10, out-of-range steps ignored
// - at start-up the target takes the line minimum
// - after turn-off each falling valley crossing increments the valley counter, saturating at 15
// - valley counter clears whenever the gate drive goes high
// - suppression time is long when valley sense low, else short
// - after turn-off the gate stays low until suppression expires
// - after suppression the gate turns on when valley count equals target
// - gate turns on after max off time regardless of valleys
// - gate turns off when scaled current exceeds feedback
// - current comparator ignored during leading edge blanking after turn-on
// - gate forced low after max on time
// - three consecutive pulses with sense below short threshold enter auto-restart
module qrst_core #(
	parameter int UPDATE_CYCLES = qrst_pkg::UPDATE_CYCLES,
	parameter int LINE_BLANK_CYCLES = qrst_pkg::LINE_BLANK_CYCLES,
	parameter int MAX_OFF_CYCLES = qrst_pkg::MAX_OFF_CYCLES,
	parameter int MAX_ON_CYCLES = qrst_pkg::MAX_ON_CYCLES
) (
	input wire logic clk, // core clock, 25 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire qrst_pkg::qrst_flags_type flags_in, // raw comparator flags
	output logic gate_drive, // gate drive request, high = on
	output logic high_line, // current line selection
	output logic [3:0] valley_target, // valley target counter
	output logic [3:0] valley_count, // valley counter
	output logic auto_restart // latched short-to-ground protection
);
	qrst_pkg::qrst_flags_type flags;
	qrst_pkg::qrst_state_type state_reg;
	logic [31:0] update_cnt_reg;
	logic [31:0] line_cnt_reg;
	logic [31:0] off_cnt_reg;
	logic [31:0] on_cnt_reg;
	logic [31:0] supp_len_reg;
	logic seen_up_reg;
	logic seen_down_reg;
	logic seen_reload_reg;
	logic started_reg;
	logic valley_prev_reg;
	logic [1:0] short_cnt_reg;
	logic period_end;
	logic valley_fall;
	logic turn_on;
	logic turn_off;
	logic [3:0] min_val;
	logic [3:0] max_val;

	// --------------------------------------------------------------
	// input synchronisation
	// --------------------------------------------------------------
	qrst_sync #(.WIDTH($bits(qrst_pkg::qrst_flags_type))) u_sync (
		.clk(clk),
		.rst(rst),
		.din(flags_in),
		.dout(flags)
	);

	// --------------------------------------------------------------
	// line selection
	// --------------------------------------------------------------
	// line dependent limits
	assign min_val = high_line ? qrst_pkg::HIGH_MIN : qrst_pkg::LOW_MIN;
	assign max_val = high_line ? qrst_pkg::HIGH_MAX : qrst_pkg::LOW_MAX;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			high_line <= 1'b0;
			line_cnt_reg <= 32'h0;
		end else if (flags.line_above_ref == high_line) begin
			line_cnt_reg <= 32'h0;
		end else if (line_cnt_reg >= 32'(LINE_BLANK_CYCLES - 1)) begin
			high_line <= flags.line_above_ref;
			line_cnt_reg <= 32'h0;
		end else begin
			line_cnt_reg <= line_cnt_reg + 32'h1;
		end
	end

	// --------------------------------------------------------------
	// update period and sticky feedback flags
	// --------------------------------------------------------------
	assign period_end = (update_cnt_reg == 32'(UPDATE_CYCLES - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			update_cnt_reg <= 32'h0;
		end else if (period_end) begin
			update_cnt_reg <= 32'h0;
		end else begin
			update_cnt_reg <= update_cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen_up_reg <= 1'b0;
			seen_down_reg <= 1'b0;
			seen_reload_reg <= 1'b0;
		end else if (period_end) begin
			seen_up_reg <= flags.fb_over_up;
			seen_down_reg <= flags.fb_over_down;
			seen_reload_reg <= flags.fb_over_reload;
		end else begin
			seen_up_reg <= seen_up_reg | flags.fb_over_up;
			seen_down_reg <= seen_down_reg | flags.fb_over_down;
			seen_reload_reg <= seen_reload_reg | flags.fb_over_reload;
		end
	end

	// --------------------------------------------------------------
	// valley target counter
	// --------------------------------------------------------------
	// start-up load, then per period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valley_target <= qrst_pkg::TARGET_RESET;
			started_reg <= 1'b0;
		end else if (!started_reg) begin
			valley_target <= min_val;
			started_reg <= 1'b1;
		end else if (valley_target < min_val) begin
			valley_target <= min_val; // line moved up, clamp into range
		end else if (valley_target > max_val) begin
			valley_target <= max_val; // line moved down
		end else if (period_end) begin
			if (seen_reload_reg || flags.fb_over_reload) begin
				valley_target <= min_val;
			end else if (seen_down_reg || flags.fb_over_down) begin
				if (valley_target > min_val) begin
					valley_target <= valley_target - 4'h1;
				end
			end else if (!(seen_up_reg || flags.fb_over_up)) begin
				// step up only if up threshold never seen
				if (valley_target < max_val) begin
					valley_target <= valley_target + 4'h1;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// valley counter
	// --------------------------------------------------------------
	assign valley_fall = flags.valley_below_ct & ~valley_prev_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valley_prev_reg <= 1'b0;
		end else begin
			valley_prev_reg <= flags.valley_below_ct;
		end
	end

	// clear on turn-on, count falling crossings
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valley_count <= qrst_pkg::VALLEY_RESET;
		end else if (turn_on) begin
			valley_count <= qrst_pkg::VALLEY_RESET;
		end else if (state_reg != qrst_pkg::QRST_ON && valley_fall && valley_count != 4'hf) begin
			valley_count <= valley_count + 4'h1;
		end
	end

	// --------------------------------------------------------------
	// switching state machine
	// --------------------------------------------------------------
	// valley match, max off override
	assign turn_on = (state_reg == qrst_pkg::QRST_OFF_WAIT) && !auto_restart &&
		((valley_count == valley_target) || (off_cnt_reg >= 32'(MAX_OFF_CYCLES - 1)));
	// current trip past blanking, max on
	assign turn_off = (state_reg == qrst_pkg::QRST_ON) &&
		((flags.current_over_fb && on_cnt_reg >= 32'(qrst_pkg::LEB_CYCLES)) ||
		(on_cnt_reg >= 32'(MAX_ON_CYCLES - 1)) || auto_restart);

	// suppression hold, length chosen at turn-off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= qrst_pkg::QRST_OFF_SUPP;
			supp_len_reg <= 32'(qrst_pkg::LONG_SUPP_CYCLES);
		end else begin
			case (state_reg)
				qrst_pkg::QRST_OFF_SUPP: begin
					if (off_cnt_reg >= supp_len_reg - 32'h1) begin
						state_reg <= qrst_pkg::QRST_OFF_WAIT;
					end
				end
				qrst_pkg::QRST_OFF_WAIT: begin
					if (turn_on) begin
						state_reg <= qrst_pkg::QRST_ON;
					end
				end
				qrst_pkg::QRST_ON: begin
					if (turn_off) begin
						state_reg <= qrst_pkg::QRST_OFF_SUPP;
						supp_len_reg <= flags.valley_below_rs ?
							32'(qrst_pkg::LONG_SUPP_CYCLES) :
							32'(qrst_pkg::SHORT_SUPP_CYCLES);
					end
				end
				default: begin
					state_reg <= qrst_pkg::QRST_OFF_SUPP;
				end
			endcase
		end
	end

	// off and on timers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			off_cnt_reg <= 32'h0;
			on_cnt_reg <= 32'h0;
		end else begin
			if (state_reg == qrst_pkg::QRST_ON) begin
				off_cnt_reg <= 32'h0;
				on_cnt_reg <= turn_off ? 32'h0 : on_cnt_reg + 32'h1;
			end else begin
				off_cnt_reg <= turn_on ? 32'h0 : off_cnt_reg + 32'h1;
				on_cnt_reg <= 32'h0;
			end
		end
	end

	// gate output register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_drive <= 1'b0;
		end else begin
			gate_drive <= turn_on | (gate_drive & ~turn_off);
		end
	end

	// --------------------------------------------------------------
	// current sense short-to-ground
	// --------------------------------------------------------------
	// consecutive low samples
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			short_cnt_reg <= 2'h0;
			auto_restart <= 1'b0;
		end else if (state_reg == qrst_pkg::QRST_ON &&
				on_cnt_reg == 32'(qrst_pkg::SHORT_SAMPLE_CYCLES)) begin
			if (flags.sense_below_short) begin
				if (short_cnt_reg == qrst_pkg::SHORT_PULSES - 2'h1) begin
					auto_restart <= 1'b1;
				end
				if (short_cnt_reg != qrst_pkg::SHORT_PULSES) begin
					short_cnt_reg <= short_cnt_reg + 2'h1;
				end
			end else begin
				short_cnt_reg <= 2'h0;
			end
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	AST_RANGE: assert property (@(posedge clk) disable iff (rst)
		started_reg && $stable(high_line) && $past(valley_target) >= min_val &&
		$past(valley_target) <= max_val |-> valley_target >= min_val && valley_target <= max_val)
		else $error("valley target out of range");
	AST_RELOAD: assert property (@(posedge clk) disable iff (rst)
		period_end && started_reg && seen_reload_reg && valley_target >= min_val &&
		valley_target <= max_val |=> valley_target == $past(min_val))
		else $error("reload did not load minimum");
	AST_HOLD: assert property (@(posedge clk) disable iff (rst)
		!period_end && started_reg && valley_target >= min_val && valley_target <= max_val
		|=> $stable(valley_target) || !$stable(high_line))
		else $error("target changed outside update");
	AST_CLEAR: assert property (@(posedge clk) disable iff (rst)
		$rose(gate_drive) |-> valley_count == 4'h0)
		else $error("valley counter not cleared at turn-on");
	AST_SUPP: assert property (@(posedge clk) disable iff (rst)
		state_reg == qrst_pkg::QRST_OFF_SUPP |=> !gate_drive)
		else $error("gate high during suppression");
	AST_MATCH: assert property (@(posedge clk) disable iff (rst)
		state_reg == qrst_pkg::QRST_OFF_WAIT && !auto_restart && valley_count == valley_target
		|=> gate_drive)
		else $error("no turn-on at valley match");
	AST_LEB: assert property (@(posedge clk) disable iff (rst)
		$rose(gate_drive) && !auto_restart |-> gate_drive [*8])
		else $error("gate on shorter than blanking");
	AST_MAXON: assert property (@(posedge clk) disable iff (rst)
		on_cnt_reg < 32'(MAX_ON_CYCLES))
		else $error("gate on beyond max on time");
	AST_MAXOFF: assert property (@(posedge clk) disable iff (rst)
		!auto_restart |-> off_cnt_reg < 32'(MAX_OFF_CYCLES + qrst_pkg::LONG_SUPP_CYCLES + 2))
		else $error("gate off beyond max off time");
	AST_OFF: assert property (@(posedge clk) disable iff (rst)
		turn_off |=> !gate_drive)
		else $error("gate did not turn off");

	COV_ON: cover property (@(posedge clk) disable iff (rst) $rose(gate_drive));
	COV_LINE: cover property (@(posedge clk) disable iff (rst) $rose(high_line));
	COV_UP: cover property (@(posedge clk) disable iff (rst)
		period_end && !seen_up_reg ##1 valley_target > min_val);
	COV_AR: cover property (@(posedge clk) disable iff (rst) $rose(auto_restart));
endmodule // qrst_core

// [qrst_plant.sv]
// model of the power switch and the analog comparators around the timing core
`timescale 1ns/1ps
module qrst_plant (
	input wire logic clk, // core clock
	input wire logic gate_drive, // gate request from the core
	input wire logic [7:0] trip_dly, // on cycles before current trip, 0 = none
	input wire logic [7:0] valley_gap, // cycles between valleys, 0 = none
	input wire logic rs_low, // valley sense below suppression threshold
	output logic current_over_fb, // scaled current above feedback
	output logic valley_below_ct, // valley sense below crossing threshold
	output logic valley_below_rs, // suppression select comparator
	output int valleys // falling crossings since turn-off
);
	int t = 0;
	int ph = 0;
	int tn = 0;
	logic prev = 1'b0;
	initial begin
		current_over_fb = 1'b0;
		valley_below_ct = 1'b0;
		valley_below_rs = 1'b0;
		valleys = 0;
	end
	// comparator levels follow the switch state, six-cycle valley pulses
	always @(negedge clk) begin
		tn = (gate_drive == prev) ? t + 1 : 1; // restart on gate change, no stale count
		ph = (valley_gap != 0) ? tn % valley_gap : 0;
		t <= tn;
		prev <= gate_drive;
		current_over_fb <= gate_drive && trip_dly != 0 && tn >= trip_dly;
		valley_below_ct <= !gate_drive && valley_gap != 0 && ph >= valley_gap - 6;
		valley_below_rs <= rs_low;
		valleys <= gate_drive ? 0 : valleys + int'(valley_gap != 0 && ph == valley_gap - 6);
	end
endmodule // qrst_plant

// [qrst_core_tb.sv]
// self-checking testbench of the switch timing core
`timescale 1ns/1ps
module qrst_core_tb;
	localparam int UPD = 200;
	localparam int MOFF = 100;
	localparam int MON = 60;
	localparam int SUP_END = qrst_pkg::SHORT_SUPP_CYCLES + 1;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic line_in = 1'b0;
	logic short_in = 1'b0;
	logic rs_low = 1'b0;
	logic [7:0] trip = 8'h00;
	logic [7:0] gap = 8'h00;
	logic [7:0] r = 8'h46;
	logic [3:0] tgt = 4'h1;
	logic mline = 1'b0, synced = 1'b0, first = 1'b1, rs_fall = 1'b0, rnd_on = 1'b1, vg_on = 1'b1;
	logic cof, vct, vrs, gate_drive, high_line, auto_restart;
	logic [3:0] valley_target, valley_count;
	int fbc = 0, n_fail = 0, checked = 0, pc = 0, smax = 0, cyc = 0, ont = 0, offt = 0;
	int valleys, lo, hi;
	qrst_pkg::qrst_flags_type flags;
	assign flags = {line_in, fbc >= 1, fbc >= 2, fbc >= 3, vct, vrs, cof, short_in};
	always #20 clk = ~clk;
	qrst_core #(.UPDATE_CYCLES(UPD), .LINE_BLANK_CYCLES(20), .MAX_OFF_CYCLES(MOFF),
		.MAX_ON_CYCLES(MON)) i_dut (.clk(clk), .rst(rst), .flags_in(flags),
		.gate_drive(gate_drive), .high_line(high_line), .valley_target(valley_target),
		.valley_count(valley_count), .auto_restart(auto_restart));
	qrst_plant i_plant (.clk(clk), .gate_drive(gate_drive), .trip_dly(trip), .valley_gap(gap),
		.rs_low(rs_low), .current_over_fb(cof), .valley_below_ct(vct),
		.valley_below_rs(vrs), .valleys(valleys));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [3:0] lo_of(input logic h);
		return h ? qrst_pkg::HIGH_MIN : qrst_pkg::LOW_MIN;
	endfunction
	function automatic logic [3:0] hi_of(input logic h);
		return h ? qrst_pkg::HIGH_MAX : qrst_pkg::LOW_MAX;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_in(input int v, input int l, input int h);
		checked++;
		if (v < l || v > h) begin
			n_fail++;
			$display("[ERR] %0t got %h range %h..%h", $time, v, l, h);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wait_mid();
		while (pc != UPD / 2) @(negedge clk);
	endtask
	task automatic wait_rise();
		@(negedge clk);
		while (gate_drive === 1'b1) @(negedge clk);
		while (gate_drive !== 1'b1) @(negedge clk);
	endtask
	task automatic run(input int c, input int n, input string nm);
		wait_mid();
		fbc = c;
		repeat (n * UPD) @(negedge clk);
		$display("test %s done", nm);
	endtask
	task automatic set_line(input logic v);
		wait_mid();
		line_in = v;
		mline = v;
		if (tgt < lo_of(v)) tgt = lo_of(v);
		if (tgt > hi_of(v)) tgt = hi_of(v);
	endtask
	// ----------------------------------------
	// target model, one step per update period
	// ----------------------------------------
	always @(negedge clk) begin
		if (synced) begin
			pc++;
			if (fbc > smax) smax = fbc;
			if (pc == UPD) begin
				if (smax == 3) tgt = lo_of(mline);
				else if (smax == 2 && tgt > lo_of(mline)) tgt = tgt - 4'h1;
				else if (smax == 0 && tgt < hi_of(mline)) tgt = tgt + 4'h1;
				smax = fbc;
				pc = 0;
			end
			if (pc == 2) begin
				chk(valley_target, tgt);
				chk(high_line, mline);
			end
		end
	end
	// gate edge monitor with random trip and valley spacing
	always @(negedge clk) begin
		if (rst) begin
			ont = 0;
			offt = 0;
			first = 1'b1;
		end else if (gate_drive) begin
			if (offt != 0) begin
				if (!first && offt > SUP_END && offt < MOFF - 2 && pc > 10 && pc < UPD / 2 - 5)
					chk(valleys, tgt);
				// at suppression end a valley may still sit in the input synchroniser
				if (!first && offt == SUP_END && pc > 10 && pc < UPD / 2 - 5)
					chk_in(valleys, tgt, tgt + 1);
				if (!first && rs_fall) chk_in(offt, 625, 640);
				if (!first && !rs_fall) chk_in(offt, 63, MOFF + 1);
				if (!first && !rs_fall && gap == 0) chk_in(offt, MOFF - 2, MOFF + 1);
				first = 1'b0;
				r = lfsr(r);
				trip <= rnd_on ? 8'h01 + r % 8'h30 : 8'h00;
				gap <= vg_on ? 8'h0c + {5'h00, r[6:4]} : 8'h00;
			end
			offt = 0;
			ont++;
			if (ont == 2) chk(valley_count, 4'h0);
		end else begin
			if (ont != 0 && !short_in) begin
				lo = (trip + 2 < 7) ? 7 : trip + 2;
				hi = (trip + 8 < 10) ? 10 : trip + 8;
				if (trip != 0) chk_in(ont, lo, hi);
				else chk_in(ont, MON, MON + 1);
			end
			if (ont != 0) rs_fall = rs_low;
			ont = 0;
			offt++;
		end
	end
	// hang limit
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			$display("[ERR] %0t timeout %h %h", $time, cyc, 20000);
			end_sim();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(valley_target, qrst_pkg::LOW_MIN);
		chk(valley_count, 4'h0);
		while (valley_target === 4'h1 && cyc < 400) @(negedge clk);
		chk(valley_target, 4'h2);
		tgt = 4'h2;
		synced = 1'b1;
		run(0, 7, "count up");
		wait_mid();
		line_in = 1'b1;
		repeat (10) @(negedge clk);
		line_in = 1'b0;
		set_line(1'b1);
		run(0, 3, "high line");
		run(1, 2, "hold");
		run(2, 9, "count down");
		run(0, 1, "step up");
		run(3, 1, "reload high");
		set_line(1'b0);
		run(0, 2, "low line");
		run(3, 1, "reload low");
		wait_rise();
		rs_low = 1'b1;
		run(0, 4, "long suppression");
		wait_rise();
		rs_low = 1'b0;
		vg_on = 1'b0;
		run(0, 2, "max off");
		rnd_on = 1'b0;
		wait_rise();
		wait_rise();
		short_in = 1'b1;
		wait_rise();
		repeat (55) @(negedge clk);
		chk(auto_restart, 1'b0);
		wait_rise();
		repeat (60) @(negedge clk);
		chk(auto_restart, 1'b1);
		repeat (150) @(negedge clk);
		chk(gate_drive, 1'b0);
		$display("test short to ground done");
		synced = 1'b0;
		short_in = 1'b0;
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk(valley_target, qrst_pkg::LOW_MIN);
		rst = 1'b0;
		@(negedge clk);
		chk(auto_restart, 1'b0);
		$display("test second reset done");
		end_sim();
	end
endmodule // qrst_core_tb
